/* cbs_pkg.sv */
// Shared constants and types for the branch, stack and logic execution core.
package cbs_pkg;
   localparam int AXI_AW = 8;
   localparam logic [15:0] RESET_PC = 16'h0000;
   localparam logic [15:0] RESET_SP = 16'h0000;
   localparam logic [15:0] VEC_BASE = 16'hFFC0;
   // Single opcodes.
   localparam logic [7:0] OP_NOP       = 8'h00;
   localparam logic [7:0] OP_RET       = 8'h20;
   localparam logic [7:0] OP_JMP_EXT   = 8'h21;
   localparam logic [7:0] OP_INTERRUPT_RETURN      = 8'h30;
   localparam logic [7:0] OP_CALL      = 8'h31;
   localparam logic [7:0] OP_PUSH_A    = 8'h40;
   localparam logic [7:0] OP_PUSH_IX   = 8'h41;
   localparam logic [7:0] OP_POP_A     = 8'h50;
   localparam logic [7:0] OP_POP_IX    = 8'h51;
   localparam logic [7:0] OP_INT_CLR   = 8'h80;
   localparam logic [7:0] OP_CARRY_CLR = 8'h81;
   localparam logic [7:0] OP_INT_SET   = 8'h90;
   localparam logic [7:0] OP_CARRY_SET = 8'h91;
   localparam logic [7:0] OP_INC_SP    = 8'hC1;
   localparam logic [7:0] OP_DEC_SP    = 8'hD1;
   localparam logic [7:0] OP_JMP_A     = 8'hE0;
   localparam logic [7:0] OP_XCH_PC    = 8'hF4;
   // Opcode groups by high bits, and operand modes by low nibble.
   localparam logic [3:0] GRP_AND  = 4'h6;
   localparam logic [3:0] GRP_OR   = 4'h7;
   localparam logic [3:0] GRP_CMPI = 4'h9;
   localparam logic [3:0] GRP_BIT  = 4'hB;
   localparam logic [4:0] GRP_VEC  = 5'h1D;
   localparam logic [4:0] GRP_BR   = 5'h1F;
   localparam logic [3:0] MODE_TL  = 4'h2;
   localparam logic [3:0] MODE_IMM = 4'h4;
   localparam logic [3:0] MODE_DIR = 4'h5;
   localparam logic [3:0] MODE_IX  = 4'h6;
   localparam logic [3:0] MODE_EP  = 4'h7;
   // Cycle counts.
   localparam logic [2:0] CYC_1 = 3'h1;
   localparam logic [2:0] CYC_2 = 3'h2;
   localparam logic [2:0] CYC_3 = 3'h3;
   localparam logic [2:0] CYC_4 = 3'h4;
   localparam logic [2:0] CYC_5 = 3'h5;
   localparam logic [2:0] CYC_6 = 3'h6;
   // Register offsets.
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_PC     = 8'h08;
   localparam logic [7:0] REG_ACC    = 8'h0C;
   localparam logic [7:0] REG_TMP    = 8'h10;
   localparam logic [7:0] REG_SP     = 8'h14;
   localparam logic [7:0] REG_IX     = 8'h18;
   localparam logic [7:0] REG_EP     = 8'h1C;
   localparam logic [7:0] REG_OPCODE = 8'h20;
   localparam logic [7:0] REG_GPR    = 8'h24;
   localparam int STATUS_BUSY_BIT = 5;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic i;
      logic n;
      logic z;
      logic v;
      logic c;
   } cbs_ccr_s;

   typedef struct packed {
      logic [15:0] addr;
      logic        we;
      logic [7:0]  wdata;
   } cbs_mem_req_s;

   typedef struct packed {
      logic              run;
      logic [2:0]        ph;
      logic [7:0]        ir;
      logic [15:0]       pc;
      logic [15:0]       a;
      logic [15:0]       t;
      logic [15:0]       sp;
      logic [15:0]       ix;
      logic [15:0]       ep;
      logic [15:0]       tmp;
      cbs_ccr_s          ccr;
      logic              aw_ok;
      logic [AXI_AW-1:0] aw_addr;
      logic              w_ok;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } cbs_state_s;
endpackage : cbs_pkg

/* cbs_regfile.sv */
// General register bank with a registered read port.
`timescale 1ns/100ps
module cbs_regfile #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 8
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic                     we,
   input  wire logic [$clog2(DEPTH)-1:0] waddr,
   input  wire logic [WIDTH-1:0]         wdata,
   input  wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic      [WIDTH-1:0]         rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rd;
   } cbs_rf_s;

   cbs_rf_s s;
   cbs_rf_s next_s;

   always_comb begin
      next_s = s;
      next_s.rd = s.mem[raddr];
      if (we) begin
         next_s.mem[waddr] = wdata;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rd;
endmodule : cbs_regfile

/* cbs_core.sv */
// Execution core for logic, compare, branch, call, return and stack opcodes.
// Behaviour
// - Byte AND of accumulator low byte with operand; N,Z set, V cleared, C kept.
// - Byte OR with same operand modes; N,Z set, V cleared, C kept.
// - Compare operand minus immediate sets all four flags, no write; 5 cycles direct/indexed.
// - Stack pointer increment or decrement by one in 3 cycles, flags untouched.
// - Branch on Z set or clear, two bytes, 3 cycles.
// - Branch on C set or clear, flags unchanged.
// - Branch on N set or clear.
// - Branch on V xor N set (less) or clear (greater-or-equal).
// - Test direct byte bit from opcode, branch on clear/set, update Z, 5 cycles.
// - Absolute jump in 3 cycles; jump to accumulator in 2 cycles.
// - Vector call through one of eight table entries, 6 cycles.
// - Absolute call saves return address, jumps, 6 cycles.
// - Exchange accumulator and program counter plus one in 3 cycles.
// - Subroutine return restores program counter from stack in 4 cycles.
// - Interrupt return restores program counter and flags in 6 cycles.
// - Word push and pop of accumulator or index register, 4 cycles each.
// - Only flags an instruction modifies change; forced flags go to 0 or 1.
`timescale 1ns/100ps
module cbs_core #(
   parameter logic [15:0] VEC_TABLE = cbs_pkg::VEC_BASE
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      s_axil_awvalid,
   output logic                           s_axil_awready,
   input  wire logic [cbs_pkg::AXI_AW-1:0] s_axil_awaddr,
   input  wire logic                      s_axil_wvalid,
   output logic                           s_axil_wready,
   input  wire logic [31:0]               s_axil_wdata,
   input  wire logic [3:0]                s_axil_wstrb,
   output logic                           s_axil_bvalid,
   input  wire logic                      s_axil_bready,
   output logic      [1:0]                s_axil_bresp,
   input  wire logic                      s_axil_arvalid,
   output logic                           s_axil_arready,
   input  wire logic [cbs_pkg::AXI_AW-1:0] s_axil_araddr,
   output logic                           s_axil_rvalid,
   input  wire logic                      s_axil_rready,
   output logic      [31:0]               s_axil_rdata,
   output logic      [1:0]                s_axil_rresp,
   output cbs_pkg::cbs_mem_req_s          mem_req,
   input  wire logic [7:0]                mem_rdata
);
   import cbs_pkg::*;

   cbs_state_s s;
   cbs_state_s next_s;
   logic       rf_we;
   logic [7:0] rf_rdata;

   function automatic logic is_logic(input logic [7:0] op);
      return (op[7:4] == GRP_AND || op[7:4] == GRP_OR) &&
             (op[3:0] == MODE_TL || op[3:0] >= MODE_IMM);
   endfunction : is_logic

   function automatic logic is_cmpi(input logic [7:0] op);
      return op[7:4] == GRP_CMPI && op[3:0] >= MODE_DIR;
   endfunction : is_cmpi

   // Total cycles including the opcode fetch; unknown opcodes idle one cycle.
   function automatic logic [2:0] instr_cycles(input logic [7:0] op);
      logic [2:0] c;
      c = CYC_1;
      if (is_logic(op)) begin
         if (op[3]) c = CYC_3;
         else if (op[3:0] == MODE_TL || op[3:0] == MODE_IMM) c = CYC_2;
         else if (op[3:0] == MODE_IX) c = CYC_4;
         else c = CYC_3;
      end else if (is_cmpi(op)) begin
         if (op[3:0] == MODE_DIR || op[3:0] == MODE_IX) c = CYC_5;
         else c = CYC_4;
      end else if (op[7:3] == GRP_BR) begin
         c = CYC_3;
      end else if (op[7:4] == GRP_BIT) begin
         c = CYC_5;
      end else if (op[7:3] == GRP_VEC || op == OP_CALL || op == OP_INTERRUPT_RETURN) begin
         c = CYC_6;
      end else if (op == OP_INC_SP || op == OP_DEC_SP || op == OP_JMP_EXT || op == OP_XCH_PC) begin
         c = CYC_3;
      end else if (op == OP_JMP_A) begin
         c = CYC_2;
      end else if (op == OP_RET || op == OP_PUSH_A || op == OP_PUSH_IX ||
                   op == OP_POP_A || op == OP_POP_IX) begin
         c = CYC_4;
      end
      return c;
   endfunction : instr_cycles

   function automatic logic [1:0] instr_bytes(input logic [7:0] op);
      logic [1:0] b;
      b = 2'h1;
      if (is_logic(op)) begin
         if (op[3:0] == MODE_IMM || op[3:0] == MODE_DIR || op[3:0] == MODE_IX) b = 2'h2;
      end else if (is_cmpi(op)) begin
         b = (op[3:0] == MODE_DIR || op[3:0] == MODE_IX) ? 2'h3 : 2'h2;
      end else if (op[7:3] == GRP_BR) begin
         b = 2'h2;
      end else if (op[7:4] == GRP_BIT || op == OP_JMP_EXT || op == OP_CALL) begin
         b = 2'h3;
      end
      return b;
   endfunction : instr_bytes

   function automatic logic [15:0] sext8(input logic [7:0] v);
      return {{8{v[7]}}, v};
   endfunction : sext8

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int k = 0; k < 4; k++) begin
         if (strb[k]) r[8*k +: 8] = nw[8*k +: 8];
      end
      return r;
   endfunction : merge

   // Returns the response code above the 32-bit read value.
   function automatic logic [33:0] reg_read(input cbs_state_s st, input logic [AXI_AW-1:0] ad);
      logic [31:0] d;
      logic [1:0]  rs;
      d  = '0;
      rs = RESP_OKAY;
      if (ad == REG_CTRL) d[0] = st.run;
      else if (ad == REG_STATUS) d[STATUS_BUSY_BIT:0] = {st.ph != 3'h0, st.ccr};
      else if (ad == REG_PC) d[15:0] = st.pc;
      else if (ad == REG_ACC) d[15:0] = st.a;
      else if (ad == REG_TMP) d[15:0] = st.t;
      else if (ad == REG_SP) d[15:0] = st.sp;
      else if (ad == REG_IX) d[15:0] = st.ix;
      else if (ad == REG_EP) d[15:0] = st.ep;
      else if (ad == REG_OPCODE) d[7:0] = st.ir;
      else if (ad != REG_GPR) rs = RESP_SLVERR;
      return {rs, d};
   endfunction : reg_read

   always_comb begin
      logic [7:0]  op;
      logic        last;
      logic        idle;
      logic [15:0] dptr;
      logic [7:0]  opnd;
      logic [7:0]  imm;
      logic [7:0]  res;
      logic [8:0]  diff;
      logic        take;
      logic        push;
      logic [2:0]  pk;
      logic [15:0] pw;
      logic [33:0] rr;
      logic [31:0] ww;
      op     = '0;
      last   = 1'b0;
      idle   = !s.run && s.ph == 3'h0;
      dptr   = '0;
      opnd   = '0;
      imm    = '0;
      res    = '0;
      diff   = '0;
      take   = 1'b0;
      push   = 1'b0;
      pk     = '0;
      pw     = '0;
      rr     = '0;
      ww     = '0;
      next_s = s;
      mem_req = '0;
      rf_we  = 1'b0;

      // Register bus slave; control accepts writes at any time, the opcode register never, all others only while halted.
      if (s.rvalid && s_axil_rready) next_s.rvalid = 1'b0;
      if (s.bvalid && s_axil_bready) next_s.bvalid = 1'b0;
      if (s_axil_arvalid && !s.rvalid) begin
         rr = reg_read(s, s_axil_araddr);
         next_s.rvalid = 1'b1;
         next_s.rdata  = rr[31:0];
         next_s.rresp  = rr[33:32];
      end
      if (s_axil_awvalid && !s.aw_ok) begin
         next_s.aw_ok   = 1'b1;
         next_s.aw_addr = s_axil_awaddr;
      end
      if (s_axil_wvalid && !s.w_ok) begin
         next_s.w_ok  = 1'b1;
         next_s.wdata = s_axil_wdata;
         next_s.wstrb = s_axil_wstrb;
      end
      if (s.aw_ok && s.w_ok && !s.bvalid) begin
         rr = reg_read(s, s.aw_addr);
         ww = merge(rr[31:0], s.wdata, s.wstrb);
         next_s.aw_ok  = 1'b0;
         next_s.w_ok   = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = rr[33:32];
         if (s.aw_addr == REG_CTRL) next_s.run = ww[0];
         else if (idle && s.aw_addr == REG_STATUS) next_s.ccr = ww[4:0];
         else if (idle && s.aw_addr == REG_PC) next_s.pc = ww[15:0];
         else if (idle && s.aw_addr == REG_ACC) next_s.a = ww[15:0];
         else if (idle && s.aw_addr == REG_TMP) next_s.t = ww[15:0];
         else if (idle && s.aw_addr == REG_SP) next_s.sp = ww[15:0];
         else if (idle && s.aw_addr == REG_IX) next_s.ix = ww[15:0];
         else if (idle && s.aw_addr == REG_EP) next_s.ep = ww[15:0];
         else if (idle && s.aw_addr == REG_GPR) rf_we = 1'b1;
      end

      if (s.ph == 3'h0) begin
         if (s.run) begin
            mem_req.addr = s.pc;
            op = mem_rdata;
            next_s.ir = op;
            next_s.pc = s.pc + 16'h0001;
            if (op == OP_CARRY_CLR) next_s.ccr.c = 1'b0;
            else if (op == OP_CARRY_SET) next_s.ccr.c = 1'b1;
            else if (op == OP_INT_CLR) next_s.ccr.i = 1'b0;
            else if (op == OP_INT_SET) next_s.ccr.i = 1'b1;
            if (instr_cycles(op) != CYC_1) next_s.ph = 3'h1;
         end
      end else begin
         op   = s.ir;
         last = s.ph == instr_cycles(op) - 3'h1;
         next_s.ph = last ? 3'h0 : s.ph + 3'h1;
         // Operand bytes follow the opcode; the second lands low, the third high.
         if (s.ph < {1'b0, instr_bytes(op)}) begin
            mem_req.addr = s.pc;
            next_s.pc = s.pc + 16'h0001;
            if (s.ph == 3'h1) next_s.tmp[7:0] = mem_rdata;
            else next_s.tmp[15:8] = mem_rdata;
         end
         if (op[3:0] == MODE_DIR) dptr = {8'h00, s.tmp[7:0]};
         else if (op[3:0] == MODE_IX) dptr = s.ix + sext8(s.tmp[7:0]);
         else dptr = s.ep;
         push = op[7:3] == GRP_VEC || op == OP_CALL || op == OP_PUSH_A || op == OP_PUSH_IX;
         pk   = (op == OP_CALL) ? 3'h3 : 3'h1;
         pw   = (op == OP_PUSH_A) ? s.a : (op == OP_PUSH_IX) ? s.ix : s.pc;

         if (is_logic(op)) begin
            if (last) begin
               if (op[3]) opnd = rf_rdata;
               else if (op[3:0] == MODE_TL) opnd = s.t[7:0];
               else if (op[3:0] == MODE_IMM) opnd = mem_rdata;
               else begin
                  mem_req.addr = dptr;
                  opnd = mem_rdata;
               end
               res = (op[7:4] == GRP_AND) ? (s.a[7:0] & opnd) : (s.a[7:0] | opnd);
               next_s.a[7:0] = res;
               next_s.ccr.n  = res[7];
               next_s.ccr.z  = res == 8'h00;
               next_s.ccr.v  = 1'b0;
            end
         end else if (is_cmpi(op)) begin
            if (last) begin
               if (op[3:0] == MODE_DIR || op[3:0] == MODE_IX) imm = s.tmp[15:8];
               else imm = s.tmp[7:0];
               if (op[3]) opnd = rf_rdata;
               else begin
                  mem_req.addr = dptr;
                  opnd = mem_rdata;
               end
               diff = {1'b0, opnd} - {1'b0, imm};
               next_s.ccr.n = diff[7];
               next_s.ccr.z = diff[7:0] == 8'h00;
               next_s.ccr.v = (opnd[7] ^ imm[7]) & (opnd[7] ^ diff[7]);
               next_s.ccr.c = diff[8];
            end
         end else if (op[7:3] == GRP_BR) begin
            if (last) begin
               case (op[2:1])
                  2'h0: take = s.ccr.c;
                  2'h1: take = s.ccr.n;
                  2'h2: take = s.ccr.z;
                  default: take = s.ccr.v ^ s.ccr.n;
               endcase
               if (take == op[0]) next_s.pc = s.pc + sext8(s.tmp[7:0]);
            end
         end else if (op[7:4] == GRP_BIT) begin
            if (last) begin
               mem_req.addr = {8'h00, s.tmp[7:0]};
               take = mem_rdata[op[2:0]];
               next_s.ccr.z = !take;
               if (take == op[3]) next_s.pc = s.pc + sext8(s.tmp[15:8]);
            end
         end else if (op == OP_INC_SP || op == OP_DEC_SP) begin
            if (last) begin
               next_s.sp = (op == OP_INC_SP) ? s.sp + 16'h0001 : s.sp - 16'h0001;
            end
         end else if (op == OP_JMP_A) begin
            next_s.pc = s.a;
         end else if (op == OP_JMP_EXT) begin
            if (last) next_s.pc = {s.tmp[7:0], mem_rdata};
         end else if (op == OP_XCH_PC) begin
            if (last) begin
               next_s.pc = s.a;
               next_s.a  = s.pc;
            end
         end else if (op == OP_RET || op == OP_INTERRUPT_RETURN || op == OP_POP_A || op == OP_POP_IX) begin
            // Stack words sit high byte first at the lower address.
            if (s.ph == 3'h1) begin
               mem_req.addr = s.sp;
               next_s.tmp[7:0] = mem_rdata;
            end else if (s.ph == 3'h2) begin
               mem_req.addr = s.sp + 16'h0001;
               next_s.tmp[15:8] = mem_rdata;
               next_s.sp = s.sp + 16'h0002;
            end else if (op == OP_INTERRUPT_RETURN && s.ph == 3'h4) begin
               mem_req.addr = s.sp + 16'h0001;
               next_s.ccr = mem_rdata[4:0];
               next_s.sp = s.sp + 16'h0002;
            end
            if (last) begin
               if (op == OP_POP_A) next_s.a = {s.tmp[7:0], s.tmp[15:8]};
               else if (op == OP_POP_IX) next_s.ix = {s.tmp[7:0], s.tmp[15:8]};
               else next_s.pc = {s.tmp[7:0], s.tmp[15:8]};
            end
         end
         if (push) begin
            // Calls and pushes share one two-cycle stack write sequence.
            if (s.ph == pk) begin
               mem_req.addr  = s.sp - 16'h0001;
               mem_req.we    = 1'b1;
               mem_req.wdata = pw[7:0];
            end else if (s.ph == pk + 3'h1) begin
               mem_req.addr  = s.sp - 16'h0002;
               mem_req.we    = 1'b1;
               mem_req.wdata = pw[15:8];
               next_s.sp     = s.sp - 16'h0002;
            end
            if (op[7:3] == GRP_VEC && (s.ph == 3'h3 || s.ph == 3'h4)) begin
               mem_req.addr = VEC_TABLE + {12'h000, op[2:0], s.ph == 3'h4};
               if (s.ph == 3'h3) next_s.tmp[7:0] = mem_rdata;
               else next_s.tmp[15:8] = mem_rdata;
            end
            if (last && op != OP_PUSH_A && op != OP_PUSH_IX) begin
               next_s.pc = {s.tmp[7:0], s.tmp[15:8]};
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s     <= '0;
         s.pc  <= RESET_PC;
         s.sp  <= RESET_SP;
      end else begin
         s <= next_s;
      end
   end

   cbs_regfile #(
      .DEPTH (8),
      .WIDTH (8)
   ) u_gpr (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (rf_we),
      .waddr   (s.wdata[10:8]),
      .wdata   (s.wdata[7:0]),
      .raddr   (s.ir[2:0]),
      .rdata   (rf_rdata)
   );

   assign s_axil_awready = !s.aw_ok;
   assign s_axil_wready  = !s.w_ok;
   assign s_axil_bvalid  = s.bvalid;
   assign s_axil_bresp   = s.bresp;
   assign s_axil_arready = !s.rvalid;
   assign s_axil_rvalid  = s.rvalid;
   assign s_axil_rdata   = s.rdata;
   assign s_axil_rresp   = s.rresp;
endmodule : cbs_core

/* cbs_core_checker.sv */
// Port-level assertions for the execution core: register bus handshakes and stack writes.
`timescale 1ns/100ps
module cbs_core_checker
   import cbs_pkg::*;
(
   input wire logic                    aclk,
   input wire logic                    aresetn,
   input wire logic                    s_axil_awvalid,
   input wire logic                    s_axil_awready,
   input wire logic                    s_axil_wvalid,
   input wire logic                    s_axil_wready,
   input wire logic                    s_axil_bvalid,
   input wire logic                    s_axil_bready,
   input wire logic                    s_axil_arvalid,
   input wire logic                    s_axil_arready,
   input wire logic [AXI_AW-1:0]       s_axil_araddr,
   input wire logic                    s_axil_rvalid,
   input wire logic                    s_axil_rready,
   input wire logic [31:0]             s_axil_rdata,
   input wire logic [1:0]              s_axil_rresp,
   input wire cbs_pkg::cbs_mem_req_s   mem_req
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // A stack word always goes out as two back-to-back byte writes.
   sequence s_stack_pair;
      mem_req.we ##1 mem_req.we ##1 !mem_req.we;
   endsequence
   sequence s_two_writes;
      mem_req.we ##1 mem_req.we;
   endsequence
   a_pair_writes: assert property ($rose(mem_req.we) |-> s_stack_pair)
      else $error("stack write not a byte pair");
   a_push_down: assert property (s_two_writes |-> mem_req.addr == $past(mem_req.addr) - 16'h0001)
      else $error("second stack byte not one below the first");
   a_b_answer: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready
      |-> ##[1:2] s_axil_bvalid) else $error("write response missing");
   a_b_drop: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid)
      else $error("write response not released");
   a_r_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
      else $error("read response missing");
   a_r_drop: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
      else $error("read response not released");
   a_aw_block: assert property (s_axil_awvalid && s_axil_awready |=> !s_axil_awready)
      else $error("write address accepted while one is held");
   a_unmapped_read: assert property (s_axil_arvalid && s_axil_arready && s_axil_araddr == 8'hFC
      |=> s_axil_rresp == RESP_SLVERR && s_axil_rdata == 32'h0) else $error("unmapped read not refused");
endmodule : cbs_core_checker

bind cbs_core cbs_core_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
   .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
   .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
   .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
   .s_axil_araddr(s_axil_araddr), .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
   .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp), .mem_req(mem_req));

/* cbs_mem_model.sv */
// Byte-wide program and data memory with a combinational read port.
`timescale 1ns/100ps
module cbs_mem_model (
   input wire logic            aclk,
   input wire cbs_pkg::cbs_mem_req_s mem_req,
   output logic [7:0]          mem_rdata
);
   import cbs_pkg::*;
   logic [7:0] m [0:65535];
   assign mem_rdata = m[mem_req.addr];
   // Plain always block so the bench may preload the array by hierarchy.
   always @(posedge aclk) begin
      if (mem_req.we) begin
         m[mem_req.addr] <= mem_req.wdata;
      end
   end
endmodule : cbs_mem_model

/* tb_cpu_logic_branch_stack_ops.sv */
// Self-checking bench: runs two short programs and checks registers, stack bytes and timing.
`timescale 1ns/100ps
module tb_cpu_logic_branch_stack_ops;
   import cbs_pkg::*;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [7:0] awa = 8'h00, ara = 8'h00, mrd;
   logic [31:0] wd = 32'h0, rd_q;
   logic awr, wr_r, bv, arr, rv;
   logic [1:0] br, rr;
   cbs_mem_req_s mq;
   int bad_count = 0, n_tests = 0, cyc = 0, t0;
   logic [7:0] prog [0:59] = '{8'h64, 8'h0F, 8'hFD, 8'h02, 8'h91, 8'h00, 8'h77, 8'h7B, 8'hFC, 8'h01,
      8'h00, 8'h91, 8'hF8, 8'h10, 8'h95, 8'h40, 8'h81, 8'hB7, 8'h40, 8'h01, 8'hBF, 8'h40, 8'h01,
      8'h00, 8'h40, 8'hC1, 8'hD1, 8'h51, 8'h31, 8'h00, 8'h30, 8'h91, 8'h21, 8'h00, 8'h20,
      8'h80, 8'hFA, 8'h01, 8'hC1, 8'hFF, 8'h01, 8'hFE, 8'h01, 8'hC1, 8'hE8, 8'h30, 8'h00, 8'h00,
      8'h20, 8'hFB, 8'h01, 8'hC1, 8'hFF, 8'h01, 8'hC1, 8'h90, 8'hF4, 8'hE0, 8'h41, 8'hE0};
   cbs_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axil_awvalid(awv), .s_axil_awready(awr),
      .s_axil_awaddr(awa), .s_axil_wvalid(wv), .s_axil_wready(wr_r), .s_axil_wdata(wd),
      .s_axil_wstrb(4'hF), .s_axil_bvalid(bv), .s_axil_bready(bry), .s_axil_bresp(br),
      .s_axil_arvalid(arv), .s_axil_arready(arr), .s_axil_araddr(ara), .s_axil_rvalid(rv),
      .s_axil_rready(rry), .s_axil_rdata(rd_q), .s_axil_rresp(rr), .mem_req(mq), .mem_rdata(mrd));
   cbs_mem_model mem (.aclk(aclk), .mem_req(mq), .mem_rdata(mrd));
   initial begin
      forever #5 aclk = ~aclk;
   end
   task automatic results;
      $display("checks=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awv <= 1;
      wv <= 1;
      bry <= 1;
      awa <= a;
      wd <= d;
      do begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wr_r) wv <= 0;
      end while (bv !== 1'b1);
      bry <= 0;
      chk(34'(br), 34'(RESP_OKAY));
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      arv <= 1;
      rry <= 1;
      ara <= a;
      do begin
         @(posedge aclk);
         if (arr) arv <= 0;
      end while (rv !== 1'b1);
      rry <= 0;
      chk({rr, rd_q}, {er, e});
   endtask : rd
   // Counts cycles between two fetch addresses while the program runs, then halts the core.
   task automatic timed_run(input logic [15:0] a0, input logic [15:0] a1, input int n);
      fork
         wr(REG_CTRL, 32'h1);
         begin
            @(posedge aclk iff mq.addr == a0);
            t0 = cyc;
            @(posedge aclk iff mq.addr == a1);
            chk(34'(cyc - t0), 34'(n));
         end
      join
      wr(REG_CTRL, 32'h0);
      repeat (8) @(posedge aclk);
   endtask : timed_run
   // The ceiling is far above the few hundred cycles the sequence needs.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      for (int i = 0; i < 65536; i++) mem.m[i] = 8'h00;
      foreach (prog[i]) mem.m[i] = prog[i];
      mem.m[16'h0040] = 8'h81;
      mem.m[16'h0101] = 8'h31;
      mem.m[16'h0103] = 8'h08;
      mem.m[VEC_BASE + 16'h0001] = 8'h30;
      mem.m[16'h0300] = 8'h3C;
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      rd(REG_SP, 32'h0, RESP_OKAY);
      wr(REG_ACC, 32'h12F0);
      wr(REG_IX, 32'h0200);
      wr(REG_EP, 32'h0300);
      wr(REG_SP, 32'h0100);
      wr(REG_GPR, 32'h030F);
      // Timing runs from the first fetch of the branch at 02 to the last byte of the final jump.
      timed_run(16'h0002, 16'h0022, 58);
      rd(REG_ACC, 32'h123F, RESP_OKAY);
      rd(REG_IX, 32'h123F, RESP_OKAY);
      rd(REG_SP, 32'h0100, RESP_OKAY);
      rd(REG_PC, 32'h0020, RESP_OKAY);
      rd(REG_STATUS, 32'h1, RESP_OKAY);
      rd(REG_OPCODE, 32'h21, RESP_OKAY);
      chk(34'(mem.m[16'h00FF]), 34'h1F);
      chk(34'(mem.m[16'h00FE]), 34'h00);
      // Second program at 23: sign branches, vector call, interrupt return, exchange, jump via A.
      // Skipped bytes bump the stack pointer, so a wrong branch shows up in SP.
      wr(REG_PC, 32'h0023);
      wr(REG_ACC, 32'h003A);
      timed_run(16'h0023, 16'h0039, 42);
      rd(REG_PC, 32'h0039, RESP_OKAY);
      rd(REG_ACC, 32'h0039, RESP_OKAY);
      rd(REG_SP, 32'h0102, RESP_OKAY);
      rd(REG_STATUS, 32'h18, RESP_OKAY);
      rd(REG_OPCODE, 32'hE0, RESP_OKAY);
      chk(34'(mem.m[16'h00FF]), 34'h2D);
      chk(34'(mem.m[16'h0103]), 34'h3F);
      chk(34'(mem.m[16'h0102]), 34'h12);
      rd(8'hFC, 32'h0, RESP_SLVERR);
      results();
   end
endmodule : tb_cpu_logic_branch_stack_ops
